// [logic/ptp_stamp_port.sv]
// Precision-time stamping port: tag FIFO, transmit and receive capture, AHB-Lite registers
// Operation
// - Single-step only while single-step enable set
// - Single-step stamp shifted by 11-bit latency adjust
// - Transparent mode adds positive correction to stamp
// - Sticky tag FIFO write/read errors until reset
// - Output 25G clock interval while stamping enabled
// - Decode opcode; reserved code acts as none
// - Single-step inserts stamp; two-step returns it
// - Ignore tag for none; echo it otherwise
// - Valid flags stamp and matching tag presented
// - Capture stamp at first beat, timer format
// - Receive stamp from first-beat cycle
// - Receive valid only in MAC plus PCS build
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ptp_stamp_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with valid/ready on both sides
// Flush empties the queue at one edge; a push in that same cycle is dropped
// Depth must be a power of two so that the pointers wrap by themselves
// Head word is read straight from the array, so it is visible while out_valid stands
module ptp_tag_fifo
    import ptp_stamp_pkg::*;
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32,
    parameter int AW = 5
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] level
);
    // Storage and bookkeeping
    logic [WIDTH-1:0] mem [DEPTH];  // Storage array
    logic [AW-1:0] wr_ptr;  // Write index
    logic [AW-1:0] rd_ptr;  // Read index
    logic [AW:0] count;  // Words held
    logic [AW:0] next_count;  // Words held after this edge
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Ready and valid are registered so the top sees flop outputs
    assign next_count = flush ? '0 : count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem[rd_ptr];
    assign level = count;

    // Storage write, no reset needed on data
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointer and flag update
    // Full and empty are decided from the count after this edge
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            // Empty queue, ready to accept
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            // Flush wins over any push or pop
            wr_ptr <= flush ? '0 : wr_ptr + AW'(push);
            rd_ptr <= flush ? '0 : rd_ptr + AW'(pop);
            count <= next_count;
            in_ready <= next_count != (AW+1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end
endmodule : ptp_tag_fifo

////////////////////////////////////////////////////////////////////////////////
// Top: stamping logic and register slave
module ptp_stamp_port
    import ptp_stamp_pkg::*;
#(
    parameter bit RX_VALID_BUILD = 1'b1  // MAC plus PCS build in 32 or 64-bit width
)
(
    input wire logic core_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Timers
    input wire logic [79:0] tx_timer,
    input wire logic [79:0] rx_timer,
    input wire logic [63:0] tx_correction,
    // Per-frame request
    input wire logic req_valid,
    output logic req_ready,
    input wire frame_req_s req,
    // Frame starts at the capture plane
    input wire logic tx_packet_first_beat,
    input wire logic [1:0] rx_packet_first_beat,
    // Results
    output logic tx_stamp_valid,
    output logic [79:0] tx_stamp,
    output logic [15:0] tx_stamp_tag,
    output logic insert_valid,
    output logic [79:0] insert_stamp,
    output logic rx_stamp_valid,
    output logic [79:0] rx_stamp,
    output logic tx_fifo_write_error,
    output logic tx_fifo_read_error,
    output logic [63:0] tx_clock_interval,
    output logic [63:0] rx_clock_interval
);
    // Register state
    logic [31:0] ctrl;  // Control register
    logic ph_write;  // Pending write data phase
    logic [11:0] ph_addr;  // Latched address
    logic tx_path_rst;  // One-cycle tx path reset pulse

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    // An address phase is taken only while the bus is ready and the transfer is NONSEQ or SEQ
    // Size is not decoded: every register is one aligned word
    wire addr_take = hsel && hready && htrans[1];
    wire rd_take = addr_take && !hwrite;
    wire wr_take = addr_take && hwrite;
    wire stamp_en = ctrl[`CTRL_STAMP_EN_BIT];
    wire single_step_on = ctrl[`CTRL_SINGLE_STEP_BIT];
    wire transp_mode = ctrl[`CTRL_TRANSP_BIT];
    wire [10:0] latency_adj = ctrl[`CTRL_LAT_MSB:`CTRL_LAT_LSB];
    wire [5:0] fifo_level;
    // Status packs both sticky errors and the queue level
    wire [31:0] status_word = {18'h0, fifo_level, 6'h0, tx_fifo_read_error, tx_fifo_write_error};
    // Full-address compare; no aliasing of the three registers
    wire hit_ctrl = haddr == `REG_CTRL_OFS;
    wire hit_status = haddr == `REG_STATUS_OFS;
    wire hit_interval = haddr == `REG_INTERVAL_OFS;
    // Unmapped addresses read zero, writes dropped
    wire [31:0] read_word = hit_ctrl ? ctrl : hit_status ? status_word :
                            hit_interval ? tx_clock_interval[31:0] : 32'h0;

    // The slave never stretches a transfer, so hreadyout stays high after reset
    // Read data is zero outside a read data phase to keep the bus quiet
    // Address phase latch and registered read data, zero wait states
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ph_write <= 1'b0;
            ph_addr <= 12'h000;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            ph_write <= wr_take;
            ph_addr <= haddr;
            hrdata <= rd_take ? read_word : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Control write; tx path reset bit self-clears
    // Writes land at the end of the data phase, when hwdata is valid
    // The path reset bit is never stored; it only fires one pulse
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= `CTRL_RESET;
            tx_path_rst <= 1'b0;
        end
        else
        begin
            tx_path_rst <= ph_write && ph_addr == `REG_CTRL_OFS && hwdata[`CTRL_TX_PATH_RST_BIT];
            if (ph_write && ph_addr == `REG_CTRL_OFS)
                ctrl <= hwdata & ~(32'h1 << `CTRL_TX_PATH_RST_BIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tag FIFO: one request per frame, drained at each frame start
    // A first beat pops the head whether or not the opcode asks for a stamp
    // Requests must therefore be queued in the same order as the frames
    frame_req_s head;  // Oldest pending request
    wire head_valid;
    wire req_ready_w;

    ptp_tag_fifo #(.WIDTH(18), .DEPTH(`TAG_FIFO_DEPTH), .AW(`TAG_FIFO_AW)) u_tag_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .flush(tx_path_rst),
        .in_valid(req_valid),
        .in_ready(req_ready_w),
        .in_data(req),
        .out_valid(head_valid),
        .out_ready(tx_packet_first_beat),
        .out_data(head),
        .level(fifo_level)
    );
    // Ready comes straight from the queue's own flop
    assign req_ready = req_ready_w;

    ////////////////////////////////////////////////////////////////////////////
    // Stamp arithmetic
    // All of the arithmetic below settles within the first-beat cycle
    // Trade-off: no pipeline stage, so the timer path to the result flops is long
    // Sign bit of the correction is taken as zero, so only 63 bits are added
    wire [63:0] corrected = tx_timer[63:0] + {1'b0, tx_correction[62:0]};
    wire [79:0] base_stamp = transp_mode ? {tx_timer[79:64], corrected} : tx_timer;
    // Normal format: whole ns into ns field with seconds carry; fraction has no home
    wire [32:0] ns_sum = {1'b0, base_stamp[31:0]} + {25'h0, latency_adj[10:3]};
    wire ns_wrap = ns_sum >= {1'b0, `NS_PER_SECOND};
    wire [31:0] ns_adj = ns_wrap ? 32'(ns_sum - {1'b0, `NS_PER_SECOND}) : ns_sum[31:0];
    // Seconds field rolls on when nanoseconds pass one second
    wire [47:0] sec_adj = base_stamp[79:32] + 48'(ns_wrap);
    // Transparent format: fraction aligned under the 16-bit fractional field
    wire [63:0] tc_adj = base_stamp[63:0] + (64'(latency_adj) << `LAT_FRAC_SHIFT);
    wire [79:0] single_stamp = transp_mode ? {base_stamp[79:64], tc_adj} : {sec_adj, ns_adj};

    // Opcode decode; reserved code and disabled single-step fall to none
    // Single-step frames while single-step is off get no stamp at all
    // A stamp is only taken when a request is waiting
    wire take = tx_packet_first_beat && head_valid;
    wire is_single = head.opcode == OP_SINGLE && single_step_on;
    wire is_double = head.opcode == OP_DOUBLE;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit result: one pulse per stamped frame
    // Stamp and tag hold their last value until the next result replaces them
    // Frames without a stamp leave the previous result untouched
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            // Nothing valid out of reset
            tx_stamp_valid <= 1'b0;
            insert_valid <= 1'b0;
            tx_stamp <= 80'h0;
            tx_stamp_tag <= 16'h0;
            insert_stamp <= 80'h0;
        end
        else
        begin
            tx_stamp_valid <= take && (is_single || is_double);
            insert_valid <= take && is_single;
            if (take && (is_single || is_double))
            begin
                tx_stamp <= is_single ? single_stamp : base_stamp;
                tx_stamp_tag <= head.tag;
            end
            if (take && is_single)
                insert_stamp <= single_stamp;
        end
    end

    // Sticky FIFO errors; cleared only by reset or tx path reset
    // A set in the same cycle as a clear wins, so no error is lost
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_fifo_write_error <= 1'b0;
            tx_fifo_read_error <= 1'b0;
        end
        else
        begin
            // Push against a full FIFO, or a frame start with no request
            tx_fifo_write_error <= (tx_fifo_write_error && !tx_path_rst) || (req_valid && !req_ready_w);
            tx_fifo_read_error <= (tx_fifo_read_error && !tx_path_rst) || (tx_packet_first_beat && !head_valid);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive capture on any segment's first beat, same cycle's timer
    // Both segments share one timer sample; two starts in one cycle give one stamp
    // Valid is left low in builds without the receive indication
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            // No stamp out of reset
            rx_stamp_valid <= 1'b0;
            rx_stamp <= 80'h0;
        end
        else
        begin
            rx_stamp_valid <= RX_VALID_BUILD && (|rx_packet_first_beat);
            if (|rx_packet_first_beat)
                rx_stamp <= rx_timer;
        end
    end

    // Clock intervals shown only while stamping is enabled
    // Only the 25G figure is supported; other line rates need another constant
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            // Intervals read zero while stamping is off
            tx_clock_interval <= 64'h0;
            rx_clock_interval <= 64'h0;
        end
        else
        begin
            tx_clock_interval <= stamp_en ? `CLOCK_INTERVAL_25G : 64'h0;
            rx_clock_interval <= stamp_en ? `CLOCK_INTERVAL_25G : 64'h0;
        end
    end

    // Unused bus inputs accepted for protocol completeness
    wire unused_ok = &{1'b0, hsize};
endmodule : ptp_stamp_port

`default_nettype wire

// [logic/ptp_stamp_defines.svh]
// Constants of the precision-time stamping port: offsets, fields, resets, figures
`ifndef PTP_STAMP_DEFINES_SVH
`define PTP_STAMP_DEFINES_SVH

// Register byte offsets on the AHB-Lite bus
`define REG_CTRL_OFS 12'h000
`define REG_STATUS_OFS 12'h004
`define REG_INTERVAL_OFS 12'h008

// Control register fields
`define CTRL_STAMP_EN_BIT 0
`define CTRL_SINGLE_STEP_BIT 1
`define CTRL_TRANSP_BIT 2
`define CTRL_TX_PATH_RST_BIT 3
`define CTRL_LAT_LSB 8
`define CTRL_LAT_MSB 18
`define CTRL_RESET 32'h0000_0000

// Status register fields
`define STATUS_WR_ERR_BIT 0
`define STATUS_RD_ERR_BIT 1
`define STATUS_LEVEL_LSB 8
`define STATUS_LEVEL_MSB 13

// Clock period in 2^-48 ns units for the 25G line rate
`define CLOCK_INTERVAL_25G 64'h0002_8f5c_28f5_c28f

// Timer layout figures
`define NS_PER_SECOND 32'h3b9a_ca00
`define LAT_FRAC_SHIFT 13

// Tag FIFO geometry
`define TAG_FIFO_DEPTH 32
`define TAG_FIFO_AW 5

`endif

// [logic/ptp_stamp_pkg.sv]
// Types shared by the precision-time stamping port
package ptp_stamp_pkg;

    // Per-frame stamping operation
    typedef enum logic [1:0] {
        OP_NONE   = 2'b00,
        OP_SINGLE = 2'b01,
        OP_DOUBLE = 2'b10,
        OP_RSVD   = 2'b11
    } stamp_op_e;

    // One frame request held in the tag FIFO
    typedef struct packed {
        logic [1:0] opcode;
        logic [15:0] tag;
    } frame_req_s;

    // Returned transmit result
    typedef struct packed {
        logic [79:0] stamp;
        logic [15:0] tag;
    } tx_result_s;

endpackage : ptp_stamp_pkg

// [bench/ptp_timer_model.sv]
// Far-side model: system timer and correction source of the client
`timescale 1ns/1ps
`default_nettype none

module ptp_timer_model
#(
    parameter logic [63:0] CORR = 64'h0000_0000_0000_0040  // Positive, bit 63 clear
)
(
    input wire logic core_clk,
    input wire logic rst,
    output logic [79:0] tx_timer,
    output logic [79:0] rx_timer,
    output logic [63:0] tx_correction
);
    ////////////////////////////////////////////////////////////////////////////////
    // Nanoseconds count up; the run is far below one second, so seconds stay zero
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            tx_timer <= 80'h0;
        else
            tx_timer <= tx_timer + 80'h1;
    end

    // Receive timer offset so a mix-up with the transmit one shows
    assign rx_timer = {48'h0, tx_timer[31:0] + 32'h100};
    // Correction already merged by the client
    assign tx_correction = CORR;
endmodule : ptp_timer_model

`default_nettype wire

// [bench/ptp_stamp_port_asserts.sv]
// Checker of the stamping port outputs
`timescale 1ns/1ps
`default_nettype none
`include "ptp_stamp_defines.svh"

module ptp_stamp_port_chk
#(
    parameter bit RX_VALID_BUILD = 1'b1
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [31:0] hwdata,
    input wire logic [79:0] rx_timer,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic tx_packet_first_beat,
    input wire logic [1:0] rx_packet_first_beat,
    input wire logic tx_stamp_valid,
    input wire logic [79:0] tx_stamp,
    input wire logic [15:0] tx_stamp_tag,
    input wire logic insert_valid,
    input wire logic rx_stamp_valid,
    input wire logic [79:0] rx_stamp,
    input wire logic tx_fifo_write_error,
    input wire logic tx_fifo_read_error,
    input wire logic [63:0] tx_clock_interval,
    input wire logic [63:0] rx_clock_interval
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Receive answer one cycle after a first beat
    sequence rx_answer;
        ##1 rx_stamp_valid;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    valid_cause_a: assert property (tx_stamp_valid |-> $past(tx_packet_first_beat))
        else $error("tx valid without first beat");
    insert_pair_a: assert property (insert_valid |-> tx_stamp_valid)
        else $error("insert without tx result");
    result_hold_a: assert property (!tx_stamp_valid |-> $stable(tx_stamp) && $stable(tx_stamp_tag))
        else $error("tx result moved without valid");
    interval_value_a: assert property (tx_clock_interval != 64'h0 |->
        tx_clock_interval == `CLOCK_INTERVAL_25G && rx_clock_interval == tx_clock_interval)
        else $error("clock interval wrong");
    rx_cause_a: assert property (rx_stamp_valid |-> $past(|rx_packet_first_beat) && rx_stamp == $past(rx_timer))
        else $error("rx stamp wrong");
    rx_answer_a: assert property (RX_VALID_BUILD && |rx_packet_first_beat |-> rx_answer)
        else $error("rx valid missing");
    write_err_a: assert property ($rose(tx_fifo_write_error) |-> $past(req_valid && !req_ready))
        else $error("write error without overflow");
    read_err_a: assert property ($rose(tx_fifo_read_error) |-> $past(tx_packet_first_beat) && !tx_stamp_valid)
        else $error("read error without first beat");
    err_clear_a: assert property ($fell(tx_fifo_write_error) || $fell(tx_fifo_read_error) |->
        $past(hwdata[3], 1) || $past(hwdata[3], 2))
        else $error("error cleared without path reset");
endmodule : ptp_stamp_port_chk

bind ptp_stamp_port ptp_stamp_port_chk #(.RX_VALID_BUILD(RX_VALID_BUILD)) chk_u (.core_clk(core_clk), .rst(rst),
    .hwdata(hwdata), .rx_timer(rx_timer), .req_valid(req_valid), .req_ready(req_ready),
    .tx_packet_first_beat(tx_packet_first_beat), .rx_packet_first_beat(rx_packet_first_beat),
    .tx_stamp_valid(tx_stamp_valid), .tx_stamp(tx_stamp), .tx_stamp_tag(tx_stamp_tag),
    .insert_valid(insert_valid), .rx_stamp_valid(rx_stamp_valid), .rx_stamp(rx_stamp),
    .tx_fifo_write_error(tx_fifo_write_error), .tx_fifo_read_error(tx_fifo_read_error),
    .tx_clock_interval(tx_clock_interval), .rx_clock_interval(rx_clock_interval));

`default_nettype wire

// [bench/tb_ptp_stamp_port.sv]
// Self-checking bench of the stamping port
`timescale 1ns/1ps
`default_nettype none
`include "ptp_stamp_defines.svh"

module tb_ptp_stamp_port
    import ptp_stamp_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic req_valid = 1'b0;
    frame_req_s req = '0;
    logic tx_packet_first_beat = 1'b0;
    logic [1:0] rx_packet_first_beat = 2'b00;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, req_ready, tx_stamp_valid, insert_valid, rx_stamp_valid;
    logic tx_fifo_write_error, tx_fifo_read_error;
    logic [79:0] tx_timer, rx_timer, tx_stamp, insert_stamp, rx_stamp, t;
    logic [63:0] tx_correction, tx_clock_interval, rx_clock_interval;
    logic [15:0] tx_stamp_tag;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    // One row per opcode case: control word, request, expected results
    typedef struct packed {logic [31:0] ctrl; logic [1:0] op; logic [15:0] tag; logic txv; logic insv;
        logic [63:0] add;} row_s;
    row_s rows [7] = '{'{32'h1, 2'b00, 16'h1111, 1'b0, 1'b0, 64'h0}, '{32'h1, 2'b11, 16'h2222, 1'b0, 1'b0, 64'h0},
        '{32'h1, 2'b10, 16'h3333, 1'b1, 1'b0, 64'h0}, '{32'h1, 2'b01, 16'h4444, 1'b0, 1'b0, 64'h0},
        '{32'h2803, 2'b01, 16'h5555, 1'b1, 1'b1, 64'h5}, '{32'h5, 2'b10, 16'h6666, 1'b1, 1'b0, 64'h40},
        '{32'h807, 2'b01, 16'h7777, 1'b1, 1'b1, 64'h1_0040}};

    ptp_stamp_port dut_u (.core_clk(core_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tx_timer(tx_timer), .rx_timer(rx_timer),
        .tx_correction(tx_correction), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .tx_packet_first_beat(tx_packet_first_beat), .rx_packet_first_beat(rx_packet_first_beat),
        .tx_stamp_valid(tx_stamp_valid), .tx_stamp(tx_stamp), .tx_stamp_tag(tx_stamp_tag),
        .insert_valid(insert_valid), .insert_stamp(insert_stamp), .rx_stamp_valid(rx_stamp_valid),
        .rx_stamp(rx_stamp), .tx_fifo_write_error(tx_fifo_write_error), .tx_fifo_read_error(tx_fifo_read_error),
        .tx_clock_interval(tx_clock_interval), .rx_clock_interval(rx_clock_interval));
    ptp_timer_model far_u (.core_clk(core_clk), .rst(rst), .tx_timer(tx_timer), .rx_timer(rx_timer),
        .tx_correction(tx_correction));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            end_of_test();
        end
    end

    task chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task end_of_test;
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // Single AHB-Lite transfer; no wait count assumed
    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        // Start on a clock edge, whatever time the caller left off at
        @(posedge core_clk);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
        chk("hresp", 1'b0, hresp);
    endtask : ahb

    // Frame start on transmit (rxb zero) or receive; t keeps the timer seen
    task beat(input logic [1:0] rxb);
        tx_packet_first_beat <= (rxb == 2'b00);
        rx_packet_first_beat <= rxb;
        @(posedge core_clk);
        t = (rxb == 2'b00) ? tx_timer : rx_timer;
        tx_packet_first_beat <= 1'b0;
        rx_packet_first_beat <= 2'b00;
        // Results stand in the cycle after the first beat; look once they have settled
        #1;
    endtask : beat

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("interval off", 80'h0, tx_clock_interval);
        foreach (rows[i])
        begin
            ahb(1'b1, `REG_CTRL_OFS, rows[i].ctrl);
            req_valid <= 1'b1;
            req <= '{opcode: rows[i].op, tag: rows[i].tag};
            @(posedge core_clk);
            req_valid <= 1'b0;
            beat(2'b00);
            chk("tx valid", rows[i].txv, tx_stamp_valid);
            chk("insert valid", rows[i].insv, insert_valid);
            if (rows[i].txv)
                chk("tag", rows[i].tag, tx_stamp_tag);
            if (rows[i].txv)
                chk("tx stamp", t + rows[i].add, tx_stamp);
            if (rows[i].insv)
                chk("insert stamp", t + rows[i].add, insert_stamp);
            #8;
            chk("one pulse", 1'b0, tx_stamp_valid);
        end
        chk("rx interval", `CLOCK_INTERVAL_25G, rx_clock_interval);
        ahb(1'b0, `REG_INTERVAL_OFS, 32'h0);
        chk("interval reg", 32'h28f5_c28f, rd);
        ahb(1'b0, 12'h00c, 32'h0);
        chk("unmapped", 32'h0, rd);
        beat(2'b10);
        chk("rx valid", 1'b1, rx_stamp_valid);
        chk("rx stamp", t, rx_stamp);
        // Fill all 32 entries, then two pushes too many
        @(posedge core_clk);
        req_valid <= 1'b1;
        repeat (34) @(posedge core_clk);
        req_valid <= 1'b0;
        ahb(1'b0, `REG_STATUS_OFS, 32'h0);
        chk("status full", 32'h0000_2001, rd);
        ahb(1'b1, `REG_CTRL_OFS, 32'h9);
        repeat (2) @(posedge core_clk);
        ahb(1'b0, `REG_STATUS_OFS, 32'h0);
        chk("status flushed", 32'h0, rd);
        beat(2'b00);
        chk("empty pop", 1'b0, tx_stamp_valid);
        repeat (4) @(posedge core_clk);
        chk("read error", 1'b1, tx_fifo_read_error);
        // Mid-run reset clears status and control
        rst <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("error reset", 1'b0, tx_fifo_read_error);
        chk("interval reset", 80'h0, tx_clock_interval);
        chk("ready reset", 1'b1, req_ready);
        // Release again and see that control came back to its reset value
        @(posedge core_clk);
        rst <= 1'b0;
        ahb(1'b0, `REG_CTRL_OFS, 32'h0);
        chk("ctrl reset", `CTRL_RESET, rd);
        end_of_test();
    end
endmodule : tb_ptp_stamp_port

`default_nettype wire
